// ===== logic/opcal_pkg.sv
/*
 * opcal_pkg: constants for the amplifier control and offset trim block.
 * Assumes APB with 32-bit data; register index times four is the address.
 */
package opcal_pkg;
    // register indices (byte address is four times the index)
    localparam logic [7:0]  OPCAL_IDX_CTRL   = 8'hEE;
    localparam logic [7:0]  OPCAL_IDX_CAL    = 8'hEF;
    localparam logic [11:0] OPCAL_ADDR_CTRL  = {2'h0, OPCAL_IDX_CTRL, 2'h0};
    localparam logic [11:0] OPCAL_ADDR_CAL   = {2'h0, OPCAL_IDX_CAL, 2'h0};
    // control register fields
    localparam int          OPCAL_POWER_BIT  = 7;
    localparam int          OPCAL_DRIVE_BIT  = 5;
    localparam int          OPCAL_CFG_LSB    = 3;
    // calibration register fields
    localparam int          OPCAL_STATUS_BIT = 7;
    localparam int          OPCAL_MODE_BIT   = 6;
    localparam int          OPCAL_REF_BIT    = 5;
    localparam int          OPCAL_TRIM_LSB   = 0;
    // reset values
    localparam logic [1:0]  OPCAL_CFG_RST    = 2'h0;
    localparam logic [4:0]  OPCAL_TRIM_RST   = 5'h00;
    // configuration codes
    typedef enum logic [1:0] {
        OPCAL_CFG_0 = 2'b00,
        OPCAL_CFG_1 = 2'b01,
        OPCAL_CFG_2 = 2'b10,
        OPCAL_CFG_3 = 2'b11
    } opcal_cfg_t;
endpackage

// ===== logic/opcal_pin_if.sv
/*
 * opcal_pin_if: carries the amplifier enable from the control core
 * to the pin gating module. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface opcal_pin_if;
    logic amp_on;
    modport ctrl (output amp_on);
    modport pins (input amp_on);
endinterface

// ===== logic/opcal_pin_gate.sv
/*
 * opcal_pin_gate: per-pin gating of digital input and output paths.
 * Assumes synchronous inputs; outputs are registered.
 */
`timescale 1ns/1ps
module opcal_pin_gate #(
    parameter int           NPINS    = 4,
    parameter logic [3:0]   AMP_PINS = 4'hF
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              pclk_en,
    // control side
    opcal_pin_if.pins              ctl,
    // pin requests
    input  wire logic [NPINS-1:0]  analog_sel,
    input  wire logic [NPINS-1:0]  dig_oe_req,
    input  wire logic [NPINS-1:0]  dig_ie_req,
    // gated pin controls
    output logic      [NPINS-1:0]  dig_oe,
    output logic      [NPINS-1:0]  dig_ie
);
    logic [NPINS-1:0] oe_d, ie_d, oe_q, ie_q;

    // one gate per pin
    genvar g;
    generate
        for (g = 0; g < NPINS; g++)
        begin : g_pin
            logic block;
            assign block = analog_sel[g]
                         | (ctl.amp_on & AMP_PINS[g]);
            assign oe_d[g] = dig_oe_req[g] & ~block;
            assign ie_d[g] = dig_ie_req[g] & ~block;
        end
    endgenerate

    // register gated controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe_q <= '0;
            ie_q <= '0;
        end
        else if (pclk_en)
        begin
            oe_q <= oe_d;
            ie_q <= ie_d;
        end
    end

    assign dig_oe = oe_q;
    assign dig_ie = ie_q;
endmodule

// ===== logic/opcal_ctrl.sv
/*
 * opcal_ctrl: APB register block for the on-chip amplifier: power,
 * configuration, calibration mode, reference select and offset trim.
 * Assumes APB master on pclk and a comparator input synchronous to pclk.
 *
// Overview of operation
// - two-bit field selects one of four configurations, calibration alike
// - amplifier is off after reset until software enables it
// - power bit set turns amplifier on, clear turns it off
// - calibration mode bit set enters offset calibration, clear returns
// - in configuration 00 reference bit picks ground or bandgap
// - trim writes take effect only while calibration mode is set
// - status follows comparator only in cal mode, config 00, drive on
// - an enabled analog function overrides digital pin functions
// - while amplifier is on its pins lose digital input and output
 */
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module opcal_ctrl #(
    parameter int           NPINS    = 4,
    parameter logic [3:0]   AMP_PINS = 4'hF
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              pclk_en,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // analog amplifier side
    input  wire logic              amp_cmp_in,
    output logic                   amp_power_on,
    output logic                   amp_output_drive_en,
    output opcal_pkg::opcal_cfg_t  amp_config_select,
    output logic                   offset_cal_mode,
    output logic                   cal_reference_select,
    output logic      [4:0]        offset_trim_code,
    // pins
    input  wire logic [NPINS-1:0]  analog_sel,
    input  wire logic [NPINS-1:0]  dig_oe_req,
    input  wire logic [NPINS-1:0]  dig_ie_req,
    output logic      [NPINS-1:0]  dig_oe,
    output logic      [NPINS-1:0]  dig_ie
);
    import opcal_pkg::*;

    logic        power_q, power_d;
    logic        drive_q, drive_d;
    opcal_cfg_t  cfg_q, cfg_d;
    logic        mode_q, mode_d;
    logic        ref_q, ref_d;
    logic [4:0]  trim_q, trim_d;
    logic        status_q, status_d;
    logic [31:0] rdata_q, rdata_d;
    logic        hit_ctrl, hit_cal, wr_en;
    logic [7:0]  ctrl_rd, cal_rd;

    opcal_pin_if pin_bus ();

    // address decode and access strobe
    assign hit_ctrl = (paddr == OPCAL_ADDR_CTRL);
    assign hit_cal  = (paddr == OPCAL_ADDR_CAL);
    assign wr_en    = psel & penable & pwrite & pclk_en;
    assign pready   = pclk_en;
    assign pslverr  = psel & penable & ~(hit_ctrl | hit_cal);

    // register images as software sees them
    always_comb
    begin
        ctrl_rd = 8'h00;
        ctrl_rd[OPCAL_POWER_BIT] = power_q;
        ctrl_rd[OPCAL_DRIVE_BIT] = drive_q;
        ctrl_rd[OPCAL_CFG_LSB +: 2] = cfg_q;
        cal_rd = 8'h00;
        cal_rd[OPCAL_STATUS_BIT] = status_q;
        cal_rd[OPCAL_MODE_BIT] = mode_q;
        cal_rd[OPCAL_REF_BIT] = ref_q;
        cal_rd[OPCAL_TRIM_LSB +: 5] = trim_q;
    end

    // next values of control state
    always_comb
    begin
        power_d  = power_q;
        drive_d  = drive_q;
        cfg_d    = cfg_q;
        mode_d   = mode_q;
        ref_d    = ref_q;
        trim_d   = trim_q;
        rdata_d  = rdata_q;
        if (wr_en && hit_ctrl)
        begin
            power_d = pwdata[OPCAL_POWER_BIT];
            drive_d = pwdata[OPCAL_DRIVE_BIT];
            cfg_d   = opcal_cfg_t'(pwdata[OPCAL_CFG_LSB +: 2]);
        end
        if (wr_en && hit_cal)
        begin
            mode_d = pwdata[OPCAL_MODE_BIT];
            ref_d  = pwdata[OPCAL_REF_BIT];
            if (mode_q)
            begin
                trim_d = pwdata[OPCAL_TRIM_LSB +: 5];
            end
        end
        // read data captured in setup phase
        if (psel && !penable)
        begin
            if (hit_ctrl)
            begin
                rdata_d = {24'h000000, ctrl_rd};
            end
            else if (hit_cal)
            begin
                rdata_d = {24'h000000, cal_rd};
            end
            else
            begin
                rdata_d = 32'h00000000;
            end
        end
    end

    // status follows comparator only in the valid state, else zero
    always_comb
    begin
        status_d = 1'b0;
        if (mode_q && (cfg_q == OPCAL_CFG_0) && drive_q)
        begin
            status_d = amp_cmp_in;
        end
    end

    // register all state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_q  <= 1'b0;
            drive_q  <= 1'b0;
            cfg_q    <= opcal_cfg_t'(OPCAL_CFG_RST);
            mode_q   <= 1'b0;
            ref_q    <= 1'b0;
            trim_q   <= OPCAL_TRIM_RST;
            status_q <= 1'b0;
            rdata_q  <= 32'h00000000;
        end
        else if (pclk_en)
        begin
            power_q  <= power_d;
            drive_q  <= drive_d;
            cfg_q    <= cfg_d;
            mode_q   <= mode_d;
            ref_q    <= ref_d;
            trim_q   <= trim_d;
            status_q <= status_d;
            rdata_q  <= rdata_d;
        end
    end

    // outputs to the bus, the analog side and the pin gate
    assign prdata               = rdata_q;
    assign amp_power_on         = power_q;
    assign amp_output_drive_en  = drive_q;
    assign amp_config_select    = cfg_q;
    assign offset_cal_mode      = mode_q;
    assign cal_reference_select = ref_q;
    assign offset_trim_code     = trim_q;
    assign pin_bus.amp_on       = power_q;

    // pin gating
    opcal_pin_gate #(
        .NPINS    (NPINS),
        .AMP_PINS (AMP_PINS)
    ) u_pins (
        .pclk       (pclk),
        .presetn    (presetn),
        .pclk_en    (pclk_en),
        .ctl        (pin_bus.pins),
        .analog_sel (analog_sel),
        .dig_oe_req (dig_oe_req),
        .dig_ie_req (dig_ie_req),
        .dig_oe     (dig_oe),
        .dig_ie     (dig_ie)
    );
endmodule

// ===== verif/opcal_ctrl_monitor.sv
/* opcal_ctrl_monitor: port assertions for opcal_ctrl.
   assumes binding onto opcal_ctrl, one clock domain. */
`timescale 1ns/1ps
module opcal_ctrl_monitor #(
    parameter int         NPINS    = 4,
    parameter logic [3:0] AMP_PINS = 4'hF
) (
    // clock, reset, bus
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             pclk_en,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic             pready,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    // amplifier and pins
    input wire logic             amp_power_on,
    input opcal_pkg::opcal_cfg_t amp_config_select,
    input wire logic             offset_cal_mode,
    input wire logic             cal_reference_select,
    input wire logic [4:0]       offset_trim_code,
    input wire logic [NPINS-1:0] analog_sel,
    input wire logic [NPINS-1:0] dig_oe,
    input wire logic [NPINS-1:0] dig_ie
);
    import opcal_pkg::*;
    logic wr_c;
    logic wr_k;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed writes per register
    assign wr_c = psel & penable & pwrite & pready
                & (paddr == OPCAL_ADDR_CTRL);
    assign wr_k = psel & penable & pwrite & pready
                & (paddr == OPCAL_ADDR_CAL);
    a_reset_off: assert property ($rose(presetn) |-> !amp_power_on)
        else $error("amplifier on after reset");
    a_power_write: assert property (
        wr_c |=> amp_power_on == $past(pwdata[7]))
        else $error("power bit not taken");
    a_cfg_write: assert property (
        wr_c |=> amp_config_select == $past(pwdata[4:3]))
        else $error("config not taken");
    a_mode_write: assert property (
        wr_k |=> offset_cal_mode == $past(pwdata[6]))
        else $error("cal mode not taken");
    a_ref_write: assert property (
        wr_k |=> cal_reference_select == $past(pwdata[5]))
        else $error("reference select not taken");
    a_trim_held: assert property (
        wr_k && !offset_cal_mode |=> $stable(offset_trim_code))
        else $error("trim changed in normal mode");
    a_trim_taken: assert property (
        wr_k && offset_cal_mode |=>
            offset_trim_code == $past(pwdata[4:0]))
        else $error("trim not taken in cal mode");
    a_pins_off: assert property (
        amp_power_on && pclk_en |=>
            ((dig_oe | dig_ie) & AMP_PINS[NPINS-1:0]) == '0)
        else $error("digital path open while amp on");
    a_analog_prio: assert property (
        pclk_en |=> ((dig_oe | dig_ie) & $past(analog_sel)) == '0)
        else $error("digital path open on analog pin");
endmodule
bind opcal_ctrl opcal_ctrl_monitor
    #(.NPINS(NPINS), .AMP_PINS(AMP_PINS)) u_mon (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
    .pwdata(pwdata), .amp_power_on(amp_power_on),
    .amp_config_select(amp_config_select), .offset_cal_mode(offset_cal_mode),
    .cal_reference_select(cal_reference_select),
    .offset_trim_code(offset_trim_code), .analog_sel(analog_sel),
    .dig_oe(dig_oe), .dig_ie(dig_ie));

// ===== verif/opcal_amp_model.sv
/* opcal_amp_model: behavioural comparator of the amplifier.
   assumes trim and mode come straight from opcal_ctrl. */
`timescale 1ns/1ps
module opcal_amp_model #(
    parameter logic [4:0] TRIP_CODE = 5'h0C
) (
    // amplifier controls
    input  wire logic       amp_power_on,
    input  wire logic       offset_cal_mode,
    input  wire logic [4:0] offset_trim_code,
    // comparator result
    output logic            amp_cmp_in
);
    // trips once trim cancels the offset; low when unpowered
    assign amp_cmp_in = amp_power_on & offset_cal_mode
                        & (offset_trim_code >= TRIP_CODE);
endmodule

// ===== verif/opcal_ctrl_test.sv
/* opcal_ctrl_test: register-level bench for opcal_ctrl.
   assumes zero-wait apb and the comparator model. */
`timescale 1ns/1ps
module opcal_ctrl_test;
    import opcal_pkg::*;
    localparam logic [4:0] TRIP = 5'h0C;
    logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cmp, pwr, drv, mode, rsel, err;
    opcal_cfg_t cfg;
    logic [4:0] trim, up_k, dn_k, avg;
    logic [3:0] asel, oe, ie;
    int miscompares, checked, cycles, i;
    opcal_ctrl uut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .amp_cmp_in(cmp), .amp_power_on(pwr), .amp_output_drive_en(drv),
        .amp_config_select(cfg), .offset_cal_mode(mode),
        .cal_reference_select(rsel), .offset_trim_code(trim),
        .analog_sel(asel), .dig_oe_req(4'hF), .dig_ie_req(4'hF),
        .dig_oe(oe), .dig_ie(ie));
    opcal_amp_model #(.TRIP_CODE(TRIP)) amp (.amp_power_on(pwr),
        .offset_cal_mode(mode), .offset_trim_code(trim), .amp_cmp_in(cmp));
    initial
    begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end
    task complete_run();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one apb transfer, result in rd and err; one more edge so outputs settle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask
    // trim write, one idle cycle, read back with status
    task step(input int k);
        apb(1'h1, OPCAL_ADDR_CAL, 32'h40 | k);
        @(posedge pclk);
        apb(1'h0, OPCAL_ADDR_CAL, 32'h0);
        chk(rd, 32'h40 | k | (k >= TRIP ? 32'h80 : 32'h0));
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, asel} = '0;
        {miscompares, checked, cycles} = '0;
        pclk_en = 1'h1;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, OPCAL_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(pwr, 1'h0);
        asel <= 4'h1;
        apb(1'h1, OPCAL_ADDR_CAL, 32'h15);
        chk(oe, 4'hE);
        apb(1'h0, OPCAL_ADDR_CAL, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            apb(1'h1, OPCAL_ADDR_CTRL, 32'h80 | (i << 3));
            apb(1'h0, OPCAL_ADDR_CTRL, 32'h0);
            chk(rd, 32'h80 | (i << 3));
            chk(cfg, 32'(i));
        end
        chk(pwr, 1'h1);
        chk({oe, ie}, 8'h00);
        apb(1'h1, OPCAL_ADDR_CTRL, 32'h0);
        chk(pwr, 1'h0);
        apb(1'h1, OPCAL_ADDR_CTRL, 32'hA0);
        chk(drv, 1'h1);
        apb(1'h1, OPCAL_ADDR_CAL, 32'h60);
        chk({mode, rsel}, 2'h3);
        apb(1'h1, OPCAL_ADDR_CAL, 32'hC0);
        step(0);
        {up_k, dn_k} = 10'h3FF;
        for (i = 0; i < 32; i++)
        begin
            step(i);
            if (rd[7] && up_k == 5'h1F) up_k = 5'(i);
        end
        chk(up_k, TRIP);
        for (i = 31; i >= 0; i--)
        begin
            step(i);
            if (!rd[7] && dn_k == 5'h1F) dn_k = 5'(i);
        end
        chk(dn_k, TRIP - 5'h1);
        avg = 5'((6'(up_k) + 6'(dn_k)) >> 1);
        apb(1'h1, OPCAL_ADDR_CAL, 32'h40 | avg);
        apb(1'h1, OPCAL_ADDR_CAL, 32'(avg));
        chk({mode, trim}, avg);
        apb(1'h1, OPCAL_ADDR_CAL, 32'h1F);
        apb(1'h0, OPCAL_ADDR_CAL, 32'h0);
        chk(rd, avg);
        apb(1'h0, 12'h000, 32'h0);
        chk(err, 1'h1);
        chk(rd, 32'h0);
        // clock enable low holds off the bus answer
        pclk_en <= 1'h0;
        @(posedge pclk);
        chk(pready, 1'h0);
        pclk_en <= 1'h1;
        complete_run();
    end
endmodule
